/* File: logic/lane_boundary.sv */
// Serial lanes, byte striping and simulation PIPE outputs of the controller
//
// The placing of the registers and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none

module lane_boundary #(
   parameter int WIN_CYC = lane_pkg::WIN_US_CYC
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // User transmit and receive words
   input wire logic [lane_pkg::BYTES*8-1:0] tx_data,
   input wire logic tx_valid,
   output logic tx_ready,
   output logic [lane_pkg::BYTES*8-1:0] rx_data,
   output logic rx_valid,
   // Serial lanes
   output logic [lane_pkg::LANES-1:0] tx_out,
   input wire logic [lane_pkg::LANES-1:0] rx_in,
   // PIPE boundary
   output lane_pkg::pipe_lane_type [lane_pkg::LANES-1:0] pipe_lane,
   output logic [1:0] rate,
   input wire logic [lane_pkg::LANES-1:0] phy_done_flag,
   input wire logic idle_event_seen,
   input wire logic eq_partner_req
);
   import lane_pkg::*;

   ctrl_type ctrl_r;
   logic [COEFF_W-1:0] coeff_r;
   logic [LANES-1:0] done_r;
   logic idle_inferred_r;
   eq_state_type eq_state_r;
   logic [LANES-1:0] active;
   logic gen3;
   logic [4:0] last_bit;
   logic [4:0] tx_cnt_r;
   logic [4:0] rx_cnt_r;
   logic tx_ready_r;
   logic tx_load;
   logic [2:0] infer_sel;
   logic [TMR_W-1:0] limit;
   logic [TMR_W-1:0] tmr_r;
   logic ctrl_wr;
   logic [31:0] rdata_nxt;

   // Active lane mask from width code
   always_comb begin
      unique case (ctrl_r.width)
         2'h0: active = 8'h01;
         2'h1: active = 8'h03;
         2'h2: active = 8'h0f;
         2'h3: active = 8'hff;
      endcase
   end

   assign gen3 = (ctrl_r.rate == RATE_GEN3);
   assign last_bit = gen3 ? 5'h1f : 5'h07;
   assign ctrl_wr = reg_wr && (reg_addr == OFS_CTRL);
   assign tx_load = tx_ready_r && tx_valid;

   // Control and coefficient registers
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_r <= CTRL_RST;
         coeff_r <= COEFF_RST;
      end else if (reg_wr) begin
         if (reg_addr == OFS_CTRL) begin
            ctrl_r <= reg_wdata[CTRL_W-1:0];
            if (reg_wdata[1:0] == RATE_RSVD) begin
               ctrl_r.rate <= ctrl_r.rate;
            end
         end
         if (reg_addr == OFS_COEFF) begin
            coeff_r <= reg_wdata[COEFF_W-1:0];
         end
      end
   end

   // Sticky completion flags, set wins over write-one clear
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         done_r <= '0;
      end else begin
         for (int i = 0; i < LANES; i++) begin
            if (phy_done_flag[i]) begin
               done_r[i] <= 1'b1;
            end else if (reg_wr && reg_addr == OFS_STATUS && reg_wdata[i]) begin
               done_r[i] <= 1'b0;
            end
         end
      end
   end

   // Selector value from mode, rate and enable
   always_comb begin
      infer_sel = INFER_NONE;
      if (ctrl_r.infer_en && !gen3) begin
         infer_sel = {1'b1, ctrl_r.infer_mode};
         if (ctrl_r.infer_mode == 2'h3 && ctrl_r.rate != RATE_GEN1) begin
            infer_sel = INFER_NONE;
         end
      end
   end

   // Inference window length in cycles
   always_comb begin
      unique case (infer_sel)
         INFER_TS: limit = (ctrl_r.rate == RATE_GEN1) ? TMR_W'(TS_GEN1_CYC)
                                                      : TMR_W'(TS_GEN2_CYC);
         INFER_EXIT_UI: limit = (ctrl_r.rate == RATE_GEN1) ? TMR_W'(EXIT_GEN1_CYC)
                                                           : TMR_W'(EXIT_GEN2_CYC);
         INFER_COM_SKP, INFER_EXIT_US: limit = TMR_W'(WIN_CYC);
         default: limit = '1;
      endcase
   end

   // Window timer and sticky idle inferred flag
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         tmr_r <= '0;
         idle_inferred_r <= 1'b0;
      end else begin
         if (!infer_sel[2] || idle_event_seen || tmr_r == limit - 1'b1) begin
            tmr_r <= '0;
         end else begin
            tmr_r <= tmr_r + 1'b1;
         end
         if (infer_sel[2] && !idle_event_seen && tmr_r == limit - 1'b1) begin
            idle_inferred_r <= 1'b1;
         end else if (reg_wr && reg_addr == OFS_STATUS && reg_wdata[ST_IDLE_BIT]) begin
            idle_inferred_r <= 1'b0;
         end
      end
   end

   // Equalization sequencer
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         eq_state_r <= EQ_IDLE;
      end else if (!gen3) begin
         eq_state_r <= EQ_IDLE;
      end else begin
         unique case (eq_state_r)
            EQ_IDLE: begin
               if (eq_partner_req) begin
                  eq_state_r <= ctrl_r.eq_bypass ? EQ_DONE : EQ_PHASE2;
               end
            end
            EQ_PHASE2: begin
               if ((phy_done_flag & active) == active) begin
                  eq_state_r <= EQ_PHASE3;
               end
            end
            EQ_PHASE3: begin
               if ((phy_done_flag & active) == active) begin
                  eq_state_r <= EQ_DONE;
               end
            end
            EQ_DONE: begin
               if (eq_partner_req) begin
                  eq_state_r <= EQ_IDLE;
               end
            end
         endcase
      end
   end

   // Rate output
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rate <= RATE_GEN1;
      end else begin
         rate <= ctrl_r.rate;
      end
   end

   // Read mux and read data for one cycle
   always_comb begin
      rdata_nxt = '0;
      unique case (reg_addr)
         OFS_CTRL: rdata_nxt = {19'h0, ctrl_r};
         OFS_COEFF: rdata_nxt = {14'h0, coeff_r};
         OFS_STATUS: rdata_nxt = {21'h0, eq_state_r, idle_inferred_r, done_r};
         OFS_LANES: rdata_nxt = {24'h0, active};
         default: rdata_nxt = '0;
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= '0;
      end else begin
         reg_rdata <= reg_rd ? rdata_nxt : 32'h0;
      end
   end

   // Transmit bit counter and ready
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_ready_r <= 1'b1;
         tx_cnt_r <= '0;
      end else if (tx_load) begin
         tx_ready_r <= 1'b0;
         tx_cnt_r <= '0;
      end else if (!tx_ready_r) begin
         tx_cnt_r <= tx_cnt_r + 1'b1;
         if (tx_cnt_r == last_bit) begin
            tx_ready_r <= 1'b1;
         end
      end
   end
   assign tx_ready = tx_ready_r;

   // Receive bit counter and word strobe
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_cnt_r <= '0;
         rx_valid <= 1'b0;
      end else begin
         rx_cnt_r <= (rx_cnt_r >= last_bit) ? 5'h00 : rx_cnt_r + 1'b1;
         rx_valid <= (rx_cnt_r >= last_bit);
      end
   end

   // Per-lane logic, identical for every lane
   generate
      for (genvar i = 0; i < LANES; i++) begin : g_lane
         logic [PIPE_W-1:0] lane_word;
         logic [PIPE_W-1:0] tx_sh_r;
         logic [PIPE_W-1:0] rx_sh_r;
         logic [PIPE_W-1:0] rx_word;

         // At Gen3 byte k of the user word goes to lane k mod 8, below Gen3 only bytes 0 to 7 are sent; inactive lanes get zero
         always_comb begin
            lane_word = '0;
            if (active[i]) begin
               lane_word[GEN12_W-1:0] = tx_data[i*8 +: 8];
               if (gen3) begin
                  lane_word[31:8] = {tx_data[(i+24)*8 +: 8], tx_data[(i+16)*8 +: 8],
                                     tx_data[(i+8)*8 +: 8]};
               end
            end
         end

         // PIPE outputs of this lane, simulation view only
         always_ff @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
               pipe_lane[i] <= '0;
            end else begin
               pipe_lane[i].lane_power_state_request <= ctrl_r.power;
               pipe_lane[i].idle_inference_select <= infer_sel;
               pipe_lane[i].lane_tx_coefficients <= gen3 ? coeff_r : '0;
               pipe_lane[i].lane_rx_preset_now <= gen3 ? ctrl_r.preset : 3'h0;
               if (tx_load) begin
                  pipe_lane[i].data <= lane_word;
               end
            end
         end

         // Serialiser, low bit first
         always_ff @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
               tx_sh_r <= '0;
               tx_out[i] <= 1'b0;
            end else if (tx_load) begin
               tx_sh_r <= lane_word;
               tx_out[i] <= 1'b0;
            end else if (!tx_ready_r) begin
               tx_out[i] <= tx_sh_r[0] & active[i];
               tx_sh_r <= {1'b0, tx_sh_r[PIPE_W-1:1]};
            end else begin
               tx_out[i] <= 1'b0;
            end
         end

         // Deserialiser, bit placed by counter
         always_comb begin
            rx_word = rx_sh_r;
            rx_word[rx_cnt_r] = rx_in[i];
            if (!gen3) begin
               rx_word[31:8] = '0;
            end
         end

         always_ff @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
               rx_sh_r <= '0;
            end else begin
               rx_sh_r[rx_cnt_r] <= rx_in[i];
            end
         end

         // Reassemble the striped receive word
         always_ff @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
               rx_data[i*8 +: 8] <= '0;
               rx_data[(i+8)*8 +: 8] <= '0;
               rx_data[(i+16)*8 +: 8] <= '0;
               rx_data[(i+24)*8 +: 8] <= '0;
            end else if (rx_cnt_r >= last_bit) begin
               rx_data[i*8 +: 8] <= active[i] ? rx_word[7:0] : 8'h00;
               rx_data[(i+8)*8 +: 8] <= active[i] ? rx_word[15:8] : 8'h00;
               rx_data[(i+16)*8 +: 8] <= active[i] ? rx_word[23:16] : 8'h00;
               rx_data[(i+24)*8 +: 8] <= active[i] ? rx_word[31:24] : 8'h00;
            end
         end
      end
   endgenerate

   // Checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   sequence eq_bypass_req;
      eq_state_r == EQ_IDLE && gen3 && eq_partner_req && ctrl_r.eq_bypass;
   endsequence

   sequence ctrl_write;
      ctrl_wr ##1 1'b1;
   endsequence

   a_infer_msb_zero: assert property (!ctrl_r.infer_en |=>
      !pipe_lane[3].idle_inference_select[2]) else $error("selector msb set without need");
   a_coeff_gen3_only: assert property (!gen3 |=>
      pipe_lane[0].lane_tx_coefficients == 18'h00000) else $error("coefficients below gen3");
   a_inactive_lane_zero: assert property (tx_load && !active[7] |=>
      pipe_lane[7].data == 32'h0) else $error("inactive lane carries data");
   a_rate_reserved_kept: assert property (ctrl_wr && reg_wdata[1:0] == 2'h3 |=>
      ctrl_r.rate == $past(ctrl_r.rate)) else $error("reserved rate accepted");
   a_done_sticky: assert property (phy_done_flag[0] |=>
      done_r[0]) else $error("completion flag lost");
   a_gen12_width: assert property (tx_load && !gen3 |=>
      pipe_lane[1].data[31:8] == 24'h0) else $error("upper lane bits used below gen3");
   a_eq_bypass_done: assert property (eq_bypass_req |=>
      eq_state_r == EQ_DONE) else $error("bypass did not skip phases");
   a_idle_timeout: assert property (infer_sel[2] && !idle_event_seen &&
      tmr_r == limit - 1'b1 |=> idle_inferred_r) else $error("idle not inferred at window end");
   a_power_follow: assert property (ctrl_write |=>
      pipe_lane[5].lane_power_state_request == $past(reg_wdata[5:4], 2))
      else $error("power request not forwarded");
   a_tx_busy_span: assert property (tx_load && !gen3 |=> !tx_ready_r [*8] ##1 tx_ready_r)
      else $error("serial byte length wrong");
endmodule

`default_nettype wire

/* File: logic/lane_pkg.sv */
// Shared constants and types for the lane and PIPE boundary
package lane_pkg;
   localparam int LANES = 8;
   localparam int PIPE_W = 32;
   localparam int GEN12_W = 8;
   localparam int COEFF_W = 18;
   localparam int BYTES = LANES * 4;
   // Register offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_COEFF = 8'h04;
   localparam logic [7:0] OFS_STATUS = 8'h08;
   localparam logic [7:0] OFS_LANES = 8'h0c;
   // Status field positions
   localparam int ST_IDLE_BIT = 8;
   localparam int ST_EQ_LSB = 9;
   // Rate encodings
   localparam logic [1:0] RATE_GEN1 = 2'h0;
   localparam logic [1:0] RATE_GEN2 = 2'h1;
   localparam logic [1:0] RATE_GEN3 = 2'h2;
   localparam logic [1:0] RATE_RSVD = 2'h3;
   // Idle inference selector values
   localparam logic [2:0] INFER_NONE = 3'h0;
   localparam logic [2:0] INFER_COM_SKP = 3'h4;
   localparam logic [2:0] INFER_TS = 3'h5;
   localparam logic [2:0] INFER_EXIT_UI = 3'h6;
   localparam logic [2:0] INFER_EXIT_US = 3'h7;
   // Timing
   localparam int CLK_PERIOD_PS = 10000;
   localparam int UI_GEN1_PS = 400;
   localparam int UI_GEN2_PS = 200;
   localparam int WIN_US = 128;
   localparam int TS_UI = 1280;
   localparam int EXIT_GEN1_UI = 2000;
   localparam int EXIT_GEN2_UI = 16000;
   localparam int WIN_US_CYC = (WIN_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int TS_GEN1_CYC = (TS_UI * UI_GEN1_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int TS_GEN2_CYC = (TS_UI * UI_GEN2_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int EXIT_GEN1_CYC = (EXIT_GEN1_UI * UI_GEN1_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int EXIT_GEN2_CYC = (EXIT_GEN2_UI * UI_GEN2_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int TMR_W = 14;
   // Control register layout, rate in the low bits
   typedef struct packed {
      logic [2:0] preset;
      logic eq_bypass;
      logic infer_en;
      logic [1:0] infer_mode;
      logic [1:0] power;
      logic [1:0] width;
      logic [1:0] rate;
   } ctrl_type;
   localparam int CTRL_W = 13;
   localparam ctrl_type CTRL_RST = '0;
   localparam logic [COEFF_W-1:0] COEFF_RST = 18'h00000;
   // Per-lane PIPE outputs
   typedef struct packed {
      logic [COEFF_W-1:0] lane_tx_coefficients;
      logic [2:0] lane_rx_preset_now;
      logic [2:0] idle_inference_select;
      logic [1:0] lane_power_state_request;
      logic [PIPE_W-1:0] data;
   } pipe_lane_type;
   typedef enum logic [1:0] {EQ_IDLE, EQ_PHASE2, EQ_PHASE3, EQ_DONE} eq_state_type;
endpackage

/* File: testbench/phy_model.sv */
// Behavioural PHY: serial loopback and completion pulses
`timescale 1ns/100ps
`default_nettype none
module phy_model #(
   parameter int DLY = 2
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Serial lanes
   input wire logic [7:0] tx_out,
   output logic [7:0] rx_in,
   // PIPE side
   input wire lane_pkg::pipe_lane_type [7:0] pipe_lane,
   input wire logic [1:0] rate,
   input wire logic done_req,
   output logic [7:0] phy_done_flag
);
   import lane_pkg::*;
   logic [1:0] rate_r;
   logic [1:0] pwr_r;
   logic [3:0] cnt_r;
   // Loopback; coefficients and preset are ignored here
   assign rx_in = tx_out;
   // Answer DLY cycles after a rate or power request
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rate_r <= 2'h0;
         pwr_r <= 2'h0;
         cnt_r <= 4'h0;
      end else begin
         rate_r <= rate;
         pwr_r <= pipe_lane[0].lane_power_state_request;
         if (rate != rate_r || pwr_r != pipe_lane[0].lane_power_state_request || done_req) begin
            cnt_r <= 4'(DLY);
         end else if (cnt_r != 4'h0) begin
            cnt_r <= cnt_r - 4'h1;
         end
      end
   end
   // One-cycle completion on every lane
   assign phy_done_flag = {8{cnt_r == 4'h1}};
endmodule
`default_nettype wire

/* File: testbench/tb_top.sv */
// Self-checking bench for the lane boundary
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   import lane_pkg::*;
   logic ref_clk, rst_n, reg_wr, reg_rd, tx_valid, tx_ready, rx_valid;
   logic [7:0] reg_addr, tx_out, rx_in, phy_done_flag;
   logic [31:0] reg_wdata, reg_rdata, v, w, e;
   logic [BYTES*8-1:0] tx_data, rx_data;
   pipe_lane_type [7:0] pipe_lane;
   logic [1:0] rate;
   logic idle_event_seen, eq_partner_req, done_req, rd_seen;
   logic [31:0] exp_q[$];
   int fails, compares, cyc, n;
   // Receive monitor state: serial history, lane mask, rate of the window
   logic [7:0] hist[32];
   logic [7:0] rx_msk;
   logic [BYTES*8-1:0] rx_exp;
   logic rx_chk, rx_g3;
   lane_boundary #(.WIN_CYC(200)) DUT (.ref_clk, .rst_n, .reg_addr, .reg_wdata,
      .reg_wr, .reg_rd, .reg_rdata, .tx_data, .tx_valid, .tx_ready, .rx_data,
      .rx_valid, .tx_out, .rx_in, .pipe_lane, .rate, .phy_done_flag,
      .idle_event_seen, .eq_partner_req);
   phy_model PHY (.ref_clk, .rst_n, .tx_out, .rx_in, .pipe_lane, .rate,
      .done_req, .phy_done_flag);
   // Compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic end_sim();
      $display("compares=%0d fails=%0d", compares, fails);
      if (fails == 0 && compares > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge ref_clk);
      @(negedge ref_clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask
   // Read; expected word goes to the queue
   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      exp_q.push_back(x);
      @(posedge ref_clk);
      reg_rd <= 1'b0;
   endtask
   // Pulse partner request or PHY completion
   task automatic kick(input bit d);
      @(posedge ref_clk);
      if (d) begin
         done_req <= 1'b1;
      end else begin
         eq_partner_req <= 1'b1;
      end
      @(posedge ref_clk);
      done_req <= 1'b0;
      eq_partner_req <= 1'b0;
      tick(6);
   endtask
   // One field on every lane
   task automatic lanes(input int f, input logic [31:0] x);
      for (int i = 0; i < LANES; i++) begin
         case (f)
            0: w = 32'(pipe_lane[i].idle_inference_select);
            1: w = 32'(pipe_lane[i].lane_power_state_request);
            2: w = 32'(pipe_lane[i].lane_tx_coefficients);
            default: w = 32'(pipe_lane[i].lane_rx_preset_now);
         endcase
         chk(w, x);
      end
   endtask
   // Clock
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   // Read data stands the cycle after the read edge
   always @(posedge ref_clk) rd_seen <= reg_rd;
   always @(negedge ref_clk) begin
      if (rd_seen === 1'b1) begin
         e = exp_q.pop_front();
         chk(reg_rdata, e);
      end
   end
   // Serial history as the receiver samples it
   always @(posedge ref_clk) begin
      hist[0] <= rx_in;
      for (int j = 1; j < 32; j++) hist[j] <= hist[j-1];
   end
   // Received word rebuilt from the history, bit n of a lane sampled n edges in
   always @(negedge ref_clk) begin
      if (rx_chk === 1'b1 && rx_valid === 1'b1) begin
         rx_exp = '0;
         for (int i = 0; i < 8; i++) begin
            for (int b = 0; b < (rx_g3 ? 32 : 8); b++) begin
               rx_exp[(i + 8 * (b / 8)) * 8 + b % 8] = hist[(rx_g3 ? 31 : 7) - b][i] & rx_msk[i];
            end
         end
         for (int j = 0; j < 8; j++) chk(rx_data[32*j +: 32], rx_exp[32*j +: 32]);
      end
   end
   // Hang guard
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         fails++;
         end_sim();
      end
   end
   // Main sequence
   initial begin
      {rst_n, reg_wr, reg_rd, tx_valid, eq_partner_req, done_req, rd_seen, rx_chk} = '0;
      {reg_addr, reg_wdata, tx_data} = '0;
      idle_event_seen = 1'b1;
      fails = 0;
      compares = 0;
      cyc = 0;
      void'($urandom(32));
      repeat (10) @(posedge ref_clk);
      rst_n <= 1'b1;
      tick(1);
      chk(32'(tx_ready), 1);
      chk(32'(rate), 0);
      rd(OFS_CTRL, 0);
      rd(8'h40, 0);
      for (int k = 0; k < 4; k++) begin
         wr(OFS_CTRL, 32'(k) << 2);
         rd(OFS_LANES, (32'h1 << (1 << k)) - 1);
      end
      // Rates, reserved code refused
      for (int k = 0; k < 3; k++) begin
         wr(OFS_CTRL, 32'hc | k);
         wr(OFS_CTRL, 32'h1f);
         tick(2);
         chk(32'(rate), k);
         rd(OFS_CTRL, 32'h1c | k);
      end
      // Power states and completion
      for (int k = 0; k < 4; k++) begin
         wr(OFS_STATUS, 32'h1ff);
         wr(OFS_CTRL, 32'hc | (k << 4));
         tick(8);
         lanes(1, k);
         rd(OFS_STATUS, 32'hff);
      end
      // Inference selector codes
      for (int k = 0; k < 4; k++) begin
         wr(OFS_CTRL, 32'h10c | (k << 6));
         tick(2);
         lanes(0, 4 | k);
         wr(OFS_CTRL, 32'hc | (k << 6));
         tick(2);
         lanes(0, 0);
      end
      wr(OFS_CTRL, 32'h1cd);
      tick(2);
      lanes(0, 0);
      wr(OFS_CTRL, 32'h10c);
      tick(8);
      @(posedge ref_clk);
      idle_event_seen <= 1'b0;
      wr(OFS_STATUS, 32'h1ff);
      tick(230);
      rd(OFS_STATUS, 32'h100);
      wr(OFS_CTRL, 32'hc);
      wr(OFS_STATUS, 32'h100);
      rd(OFS_STATUS, 0);
      // Third-generation coefficients, preset, equalization
      v = $urandom() & 32'h3ffff;
      wr(OFS_COEFF, v);
      rd(OFS_COEFF, v);
      wr(OFS_CTRL, 32'h140e);
      tick(2);
      lanes(2, v);
      lanes(3, 5);
      tick(8);
      wr(OFS_STATUS, 32'h1ff);
      kick(0);
      rd(OFS_STATUS, 32'h200);
      kick(1);
      rd(OFS_STATUS, 32'h4ff);
      kick(1);
      rd(OFS_STATUS, 32'h6ff);
      kick(0);
      rd(OFS_STATUS, 32'hff);
      // Bypass goes straight to done
      wr(OFS_CTRL, 32'h160e);
      kick(0);
      rd(OFS_STATUS, 32'h6ff);
      // Striped transmit at Gen3 then Gen1
      for (int k = 0; k < 2; k++) begin
         rx_chk = 1'b0;
         rx_g3 = (k == 0);
         rx_msk = (k == 0) ? 8'hff : 8'h0f;
         if (k == 1) begin
            wr(OFS_CTRL, 32'h8);
         end
         tick(8);
         rx_chk = 1'b1;
         @(posedge ref_clk);
         tx_valid <= 1'b1;
         for (int j = 0; j < 8; j++) tx_data[32*j +: 32] <= $urandom();
         @(posedge ref_clk);
         tx_valid <= 1'b0;
         tick(1);
         for (int i = 0; i < LANES; i++) begin
            w = rx_msk[i] ? 32'(tx_data[8*i +: 8]) : 32'h0;
            if (k == 0) begin
               w = {tx_data[8*i+192 +: 8], tx_data[8*i+128 +: 8], tx_data[8*i+64 +: 8], w[7:0]};
            end
            chk(pipe_lane[i].data, w);
            v[i] = tx_data[8*i] & rx_msk[i];
         end
         chk(32'(tx_out), 32'(v[7:0]));
         n = 0;
         while (tx_ready !== 1'b1 && n < 100) begin
            n++;
            @(negedge ref_clk);
         end
         chk(32'(n), (k == 0) ? 31 : 7);
      end
      rx_chk = 1'b0;
      lanes(2, 0);
      lanes(3, 0);
      tick(4);
      chk(32'(exp_q.size()), 0);
      end_sim();
   end
endmodule
`default_nettype wire
